/* File: hw/iwd_map.svh */
`ifndef IWD_MAP_SVH
`define IWD_MAP_SVH
// Register address and field layout of the watchdog control register.
`define IWD_CTRL_ADDR     8'h00
`define IWD_CTRL_RESET    8'h00
`define IWD_BIT_FLAG      7
`define IWD_BIT_CKSEL     6
`define IWD_BIT_RUN       5
`define IWD_BIT_SB_HI     4
`define IWD_BIT_SB_LO     3
`define IWD_BIT_OVF_HI    2
`define IWD_BIT_OVF_LO    0
// Bits that survive a reset caused by this watchdog.
`define IWD_KEEP_MASK     8'h5f
// Reset-detection flag set by a watchdog reset.
`define IWD_FLAG_MASK     8'h80
// Clear key, written by an immediate move while running.
`define IWD_CLEAR_KEY     8'h55
// Standby behaviour codes.
`define IWD_SB_CONT0      2'h0
`define IWD_SB_SUSPEND    2'h1
`define IWD_SB_PAUSE      2'h2
`define IWD_SB_CONT1      2'h3
// Smallest overflow count; code n gives this count times two to the n.
`define IWD_OVF_BASE      18'h00400
`endif

/* File: hw/iwd_pkg.sv */
package iwd_pkg;
	typedef logic [7:0]  iwd_byte_t;
	typedef logic [7:0]  iwd_addr_t;
	typedef logic [16:0] iwd_count_t;
	typedef logic [1:0]  iwd_standby_t;
	typedef logic [2:0]  iwd_ovf_sel_t;
endpackage : iwd_pkg

/* File: hw/iwd_watchdog.sv */
`timescale 1ns/10ps
`include "iwd_map.svh"
module iwd_watchdog (
	input  wire logic              core_clk,
	input  wire logic              arst_n,
	input  wire iwd_pkg::iwd_addr_t reg_addr,
	input  wire iwd_pkg::iwd_byte_t reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	input  wire logic              reg_wr_imm,
	output iwd_pkg::iwd_byte_t     reg_rdata,
	input  wire logic              rc_clk_in,
	input  wire logic              sub_clk_in,
	input  wire logic              ext_rc_wdt_reset,
	input  wire logic              standby_halt,
	input  wire logic              standby_hold,
	input  wire logic              rc_oscillator_start,
	input  wire logic              subclock_enable,
	output logic                   wdt_reset_out,
	output logic                   rc_osc_run
);
	import iwd_pkg::*;

	// Last counter value before overflow for a select code.
	function automatic iwd_count_t ovf_last(input iwd_ovf_sel_t sel);
		logic [17:0] lim;
		lim = `IWD_OVF_BASE << sel;
		return iwd_count_t'(lim - 18'h00001);
	endfunction : ovf_last

	iwd_byte_t    ctrl_reg;
	iwd_count_t   count_reg;
	logic [2:0]   rc_sync_reg;
	logic [2:0]   sub_sync_reg;
	logic         rc_lvl_reg;
	logic         sub_lvl_reg;
	logic         rc_tick_reg;
	logic         sub_tick_reg;
	logic         standby_reg;
	logic         hold_reg;

	logic         run;
	logic         cksel;
	iwd_standby_t sb_mode;
	logic         standby;
	logic         sb_entry;
	logic         hold_entry;
	logic         tick;
	logic         pause_now;
	logic         overflow;
	logic         sub_fail;
	logic         wdt_fire;
	logic         wr_ctrl;
	logic         clear_cmd;

	assign run        = ctrl_reg[`IWD_BIT_RUN];
	assign cksel      = ctrl_reg[`IWD_BIT_CKSEL];
	assign sb_mode    = ctrl_reg[`IWD_BIT_SB_HI:`IWD_BIT_SB_LO];
	assign standby    = standby_halt | standby_hold;
	assign sb_entry   = standby & ~standby_reg;
	assign hold_entry = standby_hold & ~hold_reg;
	assign wr_ctrl    = reg_wr && (reg_addr == `IWD_CTRL_ADDR);

	// Three-stage synchronisers; a level is accepted once stages two and three agree.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			rc_sync_reg  <= 3'h0;
			sub_sync_reg <= 3'h0;
		end else begin
			rc_sync_reg  <= {rc_sync_reg[1:0], rc_clk_in};
			sub_sync_reg <= {sub_sync_reg[1:0], sub_clk_in};
		end
	end

	// Accepted levels and one-cycle rising-edge ticks of both watchdog clocks.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			rc_lvl_reg   <= 1'b0;
			sub_lvl_reg  <= 1'b0;
			rc_tick_reg  <= 1'b0;
			sub_tick_reg <= 1'b0;
		end else begin
			rc_tick_reg  <= 1'b0;
			sub_tick_reg <= 1'b0;
			if (rc_sync_reg[1] == rc_sync_reg[2] && rc_sync_reg[2] != rc_lvl_reg) begin
				rc_lvl_reg  <= rc_sync_reg[2];
				rc_tick_reg <= rc_sync_reg[2];
			end
			if (sub_sync_reg[1] == sub_sync_reg[2] && sub_sync_reg[2] != sub_lvl_reg) begin
				sub_lvl_reg  <= sub_sync_reg[2];
				sub_tick_reg <= sub_sync_reg[2];
			end
		end
	end

	// Standby edge memory; these inputs come from core-clock logic and need no sync.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			standby_reg <= 1'b0;
			hold_reg    <= 1'b0;
		end else begin
			standby_reg <= standby;
			hold_reg    <= standby_hold;
		end
	end

	assign tick      = cksel ? sub_tick_reg : rc_tick_reg;
	assign pause_now = standby && (sb_mode == `IWD_SB_PAUSE);
	assign overflow  = run && tick && !pause_now && (count_reg == ovf_last(ctrl_reg[2:0]));
	// A stopped subclock cannot count, so its loss is judged from the enable bit and from entry into HOLD.
	assign sub_fail  = run && cksel && (!subclock_enable || hold_entry);
	assign wdt_fire  = overflow || sub_fail;
	assign clear_cmd = run && wr_ctrl && reg_wr_imm && (reg_wdata == `IWD_CLEAR_KEY);

	// Counter: held at zero while stopped, cleared by the key, frozen in pause.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			count_reg <= 17'h00000;
		end else if (!run || clear_cmd || wdt_fire || ext_rc_wdt_reset) begin
			count_reg <= 17'h00000;
		end else if (tick && !pause_now) begin
			count_reg <= count_reg + 17'h00001;
		end
	end

	// Control register; the flag set takes priority over any software write.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_reg <= `IWD_CTRL_RESET;
		end else if (ext_rc_wdt_reset) begin
			ctrl_reg <= `IWD_CTRL_RESET;
		end else if (wdt_fire) begin
			ctrl_reg <= (ctrl_reg & `IWD_KEEP_MASK) | `IWD_FLAG_MASK;
		end else if (run && sb_entry && sb_mode == `IWD_SB_SUSPEND) begin
			ctrl_reg[`IWD_BIT_RUN] <= 1'b0;
		end else if (wr_ctrl && !run) begin
			ctrl_reg <= reg_wdata;
		end
	end

	// Reset pulse lasts one core cycle per watchdog event.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			wdt_reset_out <= 1'b0;
		end else begin
			wdt_reset_out <= wdt_fire;
		end
	end

	// RC oscillator request; pause and suspend stop it in standby unless forced on.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			rc_osc_run <= 1'b0;
		end else begin
			rc_osc_run <= rc_oscillator_start ||
				(!cksel && run && !(standby && sb_mode[0] != sb_mode[1]));
		end
	end

	// Read data stand in the cycle after the strobe; unmapped reads return zero.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd && reg_addr == `IWD_CTRL_ADDR) begin
			reg_rdata <= ctrl_reg;
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	property p_lock;
		@(posedge core_clk) disable iff (!arst_n)
		run && !wdt_fire && !ext_rc_wdt_reset && !sb_entry |=> $stable(ctrl_reg);
	endproperty
	a_lock: assert property (p_lock) else $error("Control changed while locked.");

	property p_clear;
		@(posedge core_clk) disable iff (!arst_n)
		clear_cmd |=> count_reg == 17'h00000;
	endproperty
	a_clear: assert property (p_clear) else $error("Clear key did not zero counter.");

	property p_ovf;
		@(posedge core_clk) disable iff (!arst_n)
		overflow |=> wdt_reset_out && ctrl_reg[`IWD_BIT_FLAG] && !ctrl_reg[`IWD_BIT_RUN];
	endproperty
	a_ovf: assert property (p_ovf) else $error("Overflow missed reset or flag.");

	property p_keep;
		@(posedge core_clk) disable iff (!arst_n)
		wdt_fire && !ext_rc_wdt_reset
			|=> (ctrl_reg & `IWD_KEEP_MASK) == ($past(ctrl_reg) & `IWD_KEEP_MASK);
	endproperty
	a_keep: assert property (p_keep) else $error("Watchdog reset lost settings.");

	property p_ext;
		@(posedge core_clk) disable iff (!arst_n)
		ext_rc_wdt_reset |=> ctrl_reg == 8'h00;
	endproperty
	a_ext: assert property (p_ext) else $error("RC watchdog reset left control set.");

	property p_pause;
		@(posedge core_clk) disable iff (!arst_n)
		run && pause_now && !clear_cmd && !wdt_fire && !ext_rc_wdt_reset |=> $stable(count_reg);
	endproperty
	a_pause: assert property (p_pause) else $error("Counter moved in pause.");

	property p_sub;
		@(posedge core_clk) disable iff (!arst_n)
		run && cksel && !subclock_enable |=> wdt_reset_out ##1 !wdt_reset_out;
	endproperty
	a_sub: assert property (p_sub) else $error("Subclock loss gave no single pulse.");

	property p_osc;
		@(posedge core_clk) disable iff (!arst_n)
		rc_oscillator_start |=> rc_osc_run;
	endproperty
	a_osc: assert property (p_osc) else $error("Oscillator start ignored.");

	property p_stop;
		@(posedge core_clk) disable iff (!arst_n)
		!run |=> count_reg == 17'h00000;
	endproperty
	a_stop: assert property (p_stop) else $error("Stopped counter not zero.");

	// Each accepted tick must advance the count by exactly one, never skip or repeat.
	property p_count;
		@(posedge core_clk) disable iff (!arst_n)
		run && tick && !pause_now && !wdt_fire && !clear_cmd && !ext_rc_wdt_reset
			|=> count_reg == $past(count_reg) + 17'h00001;
	endproperty
	a_count: assert property (p_count) else $error("Counter missed a tick.");

	property p_write;
		@(posedge core_clk) disable iff (!arst_n)
		wr_ctrl && !run && !ext_rc_wdt_reset |=> ctrl_reg == $past(reg_wdata);
	endproperty
	a_write: assert property (p_write) else $error("Write to stopped timer lost.");

	property p_read;
		@(posedge core_clk) disable iff (!arst_n)
		reg_rd && reg_addr == `IWD_CTRL_ADDR |=> reg_rdata == $past(ctrl_reg);
	endproperty
	a_read: assert property (p_read) else $error("Read data differ from control.");

	property p_idle;
		@(posedge core_clk) disable iff (!arst_n)
		!reg_rd |=> reg_rdata == 8'h00;
	endproperty
	a_idle: assert property (p_idle) else $error("Read data stood too long.");

	property p_suspend;
		@(posedge core_clk) disable iff (!arst_n)
		run && sb_entry && sb_mode == `IWD_SB_SUSPEND && !ext_rc_wdt_reset |=> !run;
	endproperty
	a_suspend: assert property (p_suspend) else $error("Suspend left timer running.");

	property p_hold;
		@(posedge core_clk) disable iff (!arst_n)
		run && cksel && hold_entry && !ext_rc_wdt_reset
			|=> wdt_reset_out && ctrl_reg[`IWD_BIT_FLAG];
	endproperty
	a_hold: assert property (p_hold) else $error("HOLD on subclock gave no reset.");

	// The oscillator request is a power hazard both ways, so it is checked per case.
	property p_osc_rc;
		@(posedge core_clk) disable iff (!arst_n)
		!cksel && run && !standby |=> rc_osc_run;
	endproperty
	a_osc_rc: assert property (p_osc_rc) else $error("RC oscillator not requested.");

	property p_osc_pause;
		@(posedge core_clk) disable iff (!arst_n)
		!rc_oscillator_start && standby && sb_mode == `IWD_SB_PAUSE |=> !rc_osc_run;
	endproperty
	a_osc_pause: assert property (p_osc_pause) else $error("RC kept running in pause.");

	property p_osc_sub;
		@(posedge core_clk) disable iff (!arst_n)
		cksel && !rc_oscillator_start |=> !rc_osc_run;
	endproperty
	a_osc_sub: assert property (p_osc_sub) else $error("RC requested on subclock.");
endmodule : iwd_watchdog

/* File: verif/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
	import iwd_pkg::*;
	logic       core_clk = 0, arst_n = 0, reg_wr = 0, reg_rd = 0, reg_wr_imm = 0;
	iwd_addr_t  reg_addr = 8'h00;
	iwd_byte_t  reg_wdata = 8'h00, reg_rdata, cfg;
	logic       rc_clk_in = 0, sub_clk_in = 0, ext_rc_wdt_reset = 0;
	logic       standby_halt = 0, standby_hold = 0, rc_oscillator_start = 0;
	logic       subclock_enable = 1, wdt_reset_out, rc_osc_run;
	logic [1:0] sb;
	int         fail_count = 0, checks = 0, pulses = 0;

	iwd_watchdog iwd_watchdog_i (.core_clk(core_clk), .arst_n(arst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wr_imm(reg_wr_imm),
		.reg_rdata(reg_rdata), .rc_clk_in(rc_clk_in), .sub_clk_in(sub_clk_in),
		.ext_rc_wdt_reset(ext_rc_wdt_reset), .standby_halt(standby_halt),
		.standby_hold(standby_hold), .rc_oscillator_start(rc_oscillator_start),
		.subclock_enable(subclock_enable), .wdt_reset_out(wdt_reset_out),
		.rc_osc_run(rc_osc_run));

	// Half period of 2.5 ns gives the 200 MHz core clock.
	always #2.5 core_clk = ~core_clk;

	// Each watchdog reset pulse lasts one cycle, so counting edges counts events.
	always @(posedge core_clk) if (wdt_reset_out === 1'b1) pulses <= pulses + 1;

	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask : cyc

	task automatic chk(input string nm, input logic [16:0] e, input logic [16:0] g);
		checks++;
		if (e !== g) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic wr(input iwd_byte_t d, input logic imm);
		@(posedge core_clk);
		reg_addr <= 8'h00; reg_wdata <= d; reg_wr <= 1; reg_wr_imm <= imm;
		@(posedge core_clk);
		reg_wr <= 0; reg_wr_imm <= 0;
	endtask : wr

	task automatic rd(input iwd_addr_t a, input iwd_byte_t e);
		@(posedge core_clk);
		reg_addr <= a; reg_rd <= 1;
		@(posedge core_clk);
		reg_rd <= 0;
		// Read data stand for this one cycle only, so they are looked at mid-cycle.
		@(negedge core_clk);
		chk("control", e, reg_rdata);
		@(posedge core_clk);
	endtask : rd

	// Pin phases of four core cycles keep each level above the three-flop sampler.
	task automatic ticks(input int n, input logic sub = 1'b0);
		repeat (n) begin
			rc_clk_in  <= !sub;
			sub_clk_in <= sub;
			cyc(4);
			rc_clk_in  <= 0;
			sub_clk_in <= 0;
			cyc(4);
		end
	endtask : ticks

	// Fixed settle time covers the synchroniser plus the registered pulse.
	task automatic pc(input int e);
		cyc(6);
		chk("pulses", e, pulses);
	endtask : pc

	// Control after a watchdog reset: flag set, run cleared, other settings kept.
	function automatic iwd_byte_t fired(input iwd_byte_t c);
		return (c & 8'h5f) | 8'h80;
	endfunction : fired

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : wrap_up

	// A hang anywhere ends the run well beyond the expected 41k cycles.
	initial begin
		#300000;
		fail_count++;
		wrap_up();
	end

	initial begin
		void'($urandom(32'h3ed19b47));
		cyc(12);
		arst_n <= 1;
		rd(8'h00, 8'h00);
		rd(8'h11, 8'h00);
		cfg = iwd_byte_t'($urandom) & 8'h5f;
		wr(cfg, 0);
		rd(8'h00, cfg);
		sb = {2{1'($urandom)}};
		wr({3'b001, sb, 3'b000}, 0);
		cyc(4);
		chk("osc run", 1, rc_osc_run);
		ticks(500);
		standby_hold <= 1;
		ticks(519);
		chk("osc run", 1, rc_osc_run);
		standby_hold <= 0;
		wr(8'h00, 0);
		repeat (6) wr(iwd_byte_t'($urandom), 0);
		rd(8'h00, {3'b001, sb, 3'b000});
		wr(8'h55, 0);
		ticks(4);
		pc(0);
		ticks(1);
		pc(1);
		rd(8'h00, fired({3'b001, sb, 3'b000}));
		wr(8'h20, 0);
		rd(8'h00, 8'h20);
		ticks(1000);
		wr(8'h55, 1);
		ticks(1023);
		pc(1);
		ticks(1);
		pc(2);
		wr(8'h28, 0);
		standby_halt <= 1;
		cyc(4);
		rd(8'h00, 8'h08);
		standby_halt <= 0;
		wr(8'h30, 0);
		ticks(1000);
		standby_hold <= 1;
		cyc(4);
		chk("osc run", 0, rc_osc_run);
		ticks(50);
		standby_hold <= 0;
		ticks(23);
		pc(2);
		ticks(1);
		pc(3);
		wr(8'h60, 0);
		cyc(4);
		chk("osc run", 0, rc_osc_run);
		ticks(1023, 1);
		ticks(5);
		pc(3);
		ticks(1, 1);
		pc(4);
		rd(8'h00, fired(8'h60));
		wr(8'h60, 0);
		subclock_enable <= 0;
		pc(5);
		rd(8'h00, fired(8'h60));
		rc_oscillator_start <= 1;
		cyc(4);
		chk("osc run", 1, rc_osc_run);
		ext_rc_wdt_reset <= 1;
		cyc(1);
		ext_rc_wdt_reset <= 0;
		rd(8'h00, 8'h00);
		subclock_enable <= 1;
		wr(8'h60, 0);
		standby_hold <= 1;
		pc(6);
		standby_hold <= 0;
		rd(8'h00, fired(8'h60));
		// A pin reset in mid-run must clear the flag that the watchdog reset left set.
		arst_n <= 0;
		cyc(2);
		arst_n <= 1;
		rd(8'h00, 8'h00);
		wrap_up();
	end
endmodule : tb_top
